// file: rtl/tbp_defs.vh
// Constants for the ten-bit pulse width modulation output unit.
`ifndef TBP_DEFS_VH
`define TBP_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define TBP_OFS_PERIOD      8'h00
`define TBP_OFS_TIMER       8'h04
`define TBP_OFS_DUTY_HI     8'h08
`define TBP_OFS_SHADOW      8'h0c
`define TBP_OFS_CTRL        8'h10
`define TBP_OFS_TMR_CTRL    8'h14
`define TBP_OFS_STATUS      8'h18
`define TBP_OFS_PORTC_DIR   8'h1c
`define TBP_OFS_PORTC_DATA  8'h20

// Reset values.
`define TBP_RST_PERIOD      8'hff
`define TBP_RST_DUTY_HI     8'h00
`define TBP_RST_CTRL        6'h00
`define TBP_RST_TMR_CTRL    7'h00
`define TBP_RST_PORTC_DIR   8'hff
`define TBP_RST_PORTC_DATA  8'h00

// Control register fields.
`define TBP_CTRL_MODE_HI    3
`define TBP_CTRL_MODE_LO    2
`define TBP_CTRL_DLO_HI     5
`define TBP_CTRL_DLO_LO     4
`define TBP_MODE_PWM        2'h3

// Timer control fields: prescale select, timer on, postscale.
`define TBP_TC_PRE_HI       1
`define TBP_TC_PRE_LO       0
`define TBP_TC_ON           2
`define TBP_TC_POST_HI      6
`define TBP_TC_POST_LO      3

// Prescale selections and their last prescaler count.
`define TBP_PRE_DIV1        2'h0
`define TBP_PRE_DIV4        2'h1
`define TBP_PRE_LAST1       4'h0
`define TBP_PRE_LAST4       4'h3
`define TBP_PRE_LAST16      4'hf

// Status fields.
`define TBP_ST_POST_FLAG    0
`define TBP_ST_OUT_LEVEL    1
`define TBP_ST_PWM_ACTIVE   2

// Pin used on port C and last oscillator period count of an instruction cycle.
`define TBP_PORTC_PWM_BIT   2
`define TBP_Q_LAST          2'h3

// AXI responses.
`define TBP_RESP_OKAY       2'h0
`define TBP_RESP_SLVERR     2'h2

`endif

// file: rtl/tbp_timebase.v
// Quarter-cycle clock, prescaler, base timer and postscaler.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.vh"

module tbp_timebase (
  // Clock and reset.
  input  wire       aclk,
  input  wire       aresetn,
  // Configuration.
  input  wire       timer_on,
  input  wire [1:0] pre_sel,
  input  wire [3:0] post_sel,
  input  wire [7:0] period_match_reg,
  // Time base state.
  output reg  [7:0] base_timer_count,
  output wire [1:0] low_bits,
  output wire       period_tick,
  output wire       post_tick
);

  reg  [1:0] q_ff;
  reg  [3:0] pre_ff;
  reg  [3:0] post_ff;
  wire [3:0] pre_last;
  wire       inc;

  assign pre_last = (pre_sel == `TBP_PRE_DIV1) ? `TBP_PRE_LAST1 :
                    (pre_sel == `TBP_PRE_DIV4) ? `TBP_PRE_LAST4 : `TBP_PRE_LAST16;
  // The timer steps once per prescaled instruction cycle of four oscillator periods.
  assign inc = timer_on && (q_ff == `TBP_Q_LAST) && (pre_ff == pre_last); // [R15]
  assign period_tick = inc && (base_timer_count == period_match_reg); // [R1] [R2]
  // The postscaler only gives a slower event; it never shortens the period.
  assign post_tick = period_tick && (post_ff == post_sel); // [R13]
  // Two lower bits extend the timer so that the duty resolves to one oscillator period times the prescale.
  assign low_bits = (pre_sel == `TBP_PRE_DIV1) ? q_ff :
                    (pre_sel == `TBP_PRE_DIV4) ? pre_ff[1:0] : pre_ff[3:2]; // [R9] [R14]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_ff             <= 2'h0;
      pre_ff           <= 4'h0;
      post_ff          <= 4'h0;
      base_timer_count <= 8'h00;
    end
    else
    begin
      q_ff <= q_ff + 2'h1;
      if (timer_on && (q_ff == `TBP_Q_LAST))
        pre_ff <= (pre_ff == pre_last) ? 4'h0 : pre_ff + 4'h1;
      if (inc)
        base_timer_count <= period_tick ? 8'h00 : base_timer_count + 8'h01; // [R2]
      if (post_tick)
        post_ff <= 4'h0;
      else if (period_tick)
        post_ff <= post_ff + 4'h1;
    end
  end

endmodule // tbp_timebase

`default_nettype wire

// file: rtl/tbp_pwm_core.v
// Double-buffered duty latch, comparator and output latch.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.vh"

module tbp_pwm_core (
  // Clock and reset.
  input  wire       aclk,
  input  wire       aresetn,
  // Mode and duty.
  input  wire       pwm_en,
  input  wire [9:0] duty_pending,
  input  wire       period_tick,
  input  wire [9:0] time_ext,
  // Software access to the shadow outside modulation mode.
  input  wire       shadow_wr,
  input  wire [7:0] shadow_wdata,
  // State.
  output reg  [7:0] duty_shadow_reg,
  output reg        pwm_out_ff
);

  reg [1:0] latch2_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      duty_shadow_reg <= 8'h00; // [R16]
      latch2_ff       <= 2'h0;
      pwm_out_ff      <= 1'b0;
    end
    else if (!pwm_en)
    begin
      // Leaving modulation mode, including a cleared control register, drops the latch.
      pwm_out_ff <= 1'b0; // [R11]
      if (shadow_wr)
        duty_shadow_reg <= shadow_wdata;
    end
    else if (period_tick)
    begin
      duty_shadow_reg <= duty_pending[9:2]; // [R2] [R6] [R8]
      latch2_ff       <= duty_pending[1:0]; // [R8]
      pwm_out_ff      <= (duty_pending != 10'h000); // [R2] [R3]
    end
    else if ({duty_shadow_reg, latch2_ff} == time_ext)
      // A duty beyond the period never matches, so the output stays high.
      pwm_out_ff <= 1'b0; // [R5] [R9] [R10]
  end

endmodule // tbp_pwm_core

`default_nettype wire

// file: rtl/tbp_top.v
// Ten-bit pulse width modulation output unit with an AXI4-Lite register slave.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.vh"

// Summary of operation
// [R1] Period is (period match plus one) times four oscillator periods times prescale.
// [R2] After timer equals period match: clear timer, load shadow, set output.
// [R3] A zero duty never sets the output at a period start.
// [R4] Duty is duty high register in top bits, control bits 5:4 below.
// [R5] Output high time is duty times oscillator period times prescale.
// [R6] Duty writes are taken any time and applied after the next match.
// [R7] In modulation mode software cannot write the duty shadow.
// [R8] Duty shadow plus a two-bit latch double buffer the duty.
// [R9] Output goes low when buffered duty equals the extended timer.
// [R10] Duty beyond the period leaves the output high all period.
// [R11] Clearing the control register forces the output latch low, not port data.
// [R12] Software clears port C direction bit two to drive the pin.
// [R13] The postscaler does not enter the period; it gives a slower event.
// [R14] Duty resolution is limited by oscillator over output frequency, ten bits max.
// [R15] Timer steps once per prescaled instruction cycle of four oscillator periods.
// [R16] After reset output is low, shadow and latch cleared until first match.
module tbp_top (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address channel.
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  // AXI4-Lite write data channel.
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // AXI4-Lite write response channel.
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read address channel.
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  // AXI4-Lite read data channel.
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Shared port C pin carrying the modulated output.
  output reg         modulated_output_pin,
  output reg         modulated_output_pin_oe
);

  // Software registers.
  reg  [7:0]  period_match_reg_ff;
  reg  [7:0]  duty_high_bits_reg_ff;
  reg  [5:0]  capture_compare_control_ff;
  reg  [6:0]  timer_ctrl_ff;
  reg  [7:0]  port_c_direction_ff;
  reg  [7:0]  port_c_data_ff;
  reg         post_flag_ff;

  // Write channel capture.
  reg  [7:0]  aw_addr_ff;
  reg         aw_got_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_got_ff;

  // Read mux.
  reg  [31:0] nxt_rdata;
  reg  [1:0]  nxt_rresp;

  // Time base and core state.
  wire [7:0]  base_timer_count;
  wire [1:0]  low_bits;
  wire        period_tick;
  wire        post_tick;
  wire [7:0]  duty_shadow_reg;
  wire        pwm_out;
  wire        pwm_en;
  wire [9:0]  duty_pending;
  reg         period_start_ff;

  // Write strobes.
  wire        wr_go;
  wire        wr_lane0;
  wire        wr_hit_period;
  wire        wr_hit_duty;
  wire        wr_hit_shadow;
  wire        wr_hit_ctrl;
  wire        wr_hit_tctrl;
  wire        wr_hit_status;
  wire        wr_hit_dir;
  wire        wr_hit_data;
  wire        wr_mapped;
  wire        rd_go;

  assign pwm_en = (capture_compare_control_ff[`TBP_CTRL_MODE_HI:`TBP_CTRL_MODE_LO]
                   == `TBP_MODE_PWM);
  assign duty_pending = {duty_high_bits_reg_ff,
                         capture_compare_control_ff[`TBP_CTRL_DLO_HI:`TBP_CTRL_DLO_LO]}; // [R4]

  // Each address and data beat is held until both are present and the response is gone.
  assign awready = !aw_got_ff && !bvalid;
  assign wready  = !w_got_ff && !bvalid;
  assign arready = !rvalid;

  assign wr_go    = aw_got_ff && w_got_ff && !bvalid;
  assign wr_lane0 = wr_go && w_strb_ff[0];
  assign rd_go    = arvalid && !rvalid;

  assign wr_hit_period = wr_lane0 && (aw_addr_ff == `TBP_OFS_PERIOD);
  assign wr_hit_duty   = wr_lane0 && (aw_addr_ff == `TBP_OFS_DUTY_HI);
  assign wr_hit_shadow = wr_lane0 && (aw_addr_ff == `TBP_OFS_SHADOW);
  assign wr_hit_ctrl   = wr_lane0 && (aw_addr_ff == `TBP_OFS_CTRL);
  assign wr_hit_tctrl  = wr_lane0 && (aw_addr_ff == `TBP_OFS_TMR_CTRL);
  assign wr_hit_status = wr_lane0 && (aw_addr_ff == `TBP_OFS_STATUS);
  assign wr_hit_dir    = wr_lane0 && (aw_addr_ff == `TBP_OFS_PORTC_DIR);
  assign wr_hit_data   = wr_lane0 && (aw_addr_ff == `TBP_OFS_PORTC_DATA);

  // The timer register is read-only; a write to it is accepted and ignored.
  assign wr_mapped = (aw_addr_ff == `TBP_OFS_PERIOD) ||
                     (aw_addr_ff == `TBP_OFS_TIMER) ||
                     (aw_addr_ff == `TBP_OFS_DUTY_HI) ||
                     (aw_addr_ff == `TBP_OFS_SHADOW) ||
                     (aw_addr_ff == `TBP_OFS_CTRL) ||
                     (aw_addr_ff == `TBP_OFS_TMR_CTRL) ||
                     (aw_addr_ff == `TBP_OFS_STATUS) ||
                     (aw_addr_ff == `TBP_OFS_PORTC_DIR) ||
                     (aw_addr_ff == `TBP_OFS_PORTC_DATA);

  tbp_timebase u_timebase (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .timer_on         (timer_ctrl_ff[`TBP_TC_ON]),
    .pre_sel          (timer_ctrl_ff[`TBP_TC_PRE_HI:`TBP_TC_PRE_LO]),
    .post_sel         (timer_ctrl_ff[`TBP_TC_POST_HI:`TBP_TC_POST_LO]),
    .period_match_reg (period_match_reg_ff),
    .base_timer_count (base_timer_count),
    .low_bits         (low_bits),
    .period_tick      (period_tick),
    .post_tick        (post_tick)
  );

  tbp_pwm_core u_core (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .pwm_en          (pwm_en),
    .duty_pending    (duty_pending),
    .period_tick     (period_start_ff),
    .time_ext        ({base_timer_count, low_bits}),
    .shadow_wr       (wr_hit_shadow), // [R7]
    .shadow_wdata    (w_data_ff[7:0]),
    .duty_shadow_reg (duty_shadow_reg),
    .pwm_out_ff      (pwm_out)
  );

  // The new period starts one cycle after the match, when the extended timer already reads zero.
  // The comparator is registered, so setting the output here gives rise and fall the same lag
  // and the high time is exactly the duty value.
  always @(posedge aclk)
  begin
    if (!aresetn)
      period_start_ff <= 1'b0;
    else
      period_start_ff <= period_tick; // [R2] [R5]
  end

  // Write address and data capture, write response.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_ff <= 8'h00;
      aw_got_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      w_got_ff   <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `TBP_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr_ff <= awaddr;
        aw_got_ff  <= 1'b1;
      end
      if (wvalid && wready)
      begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
        w_got_ff  <= 1'b1;
      end
      if (wr_go)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_mapped ? `TBP_RESP_OKAY : `TBP_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Software register writes; duty writes land in the pending copy at any time.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_match_reg_ff        <= `TBP_RST_PERIOD;
      duty_high_bits_reg_ff      <= `TBP_RST_DUTY_HI;
      capture_compare_control_ff <= `TBP_RST_CTRL;
      timer_ctrl_ff              <= `TBP_RST_TMR_CTRL;
      port_c_direction_ff        <= `TBP_RST_PORTC_DIR;
      port_c_data_ff             <= `TBP_RST_PORTC_DATA;
    end
    else
    begin
      if (wr_hit_period)
        period_match_reg_ff <= w_data_ff[7:0];
      if (wr_hit_duty)
        duty_high_bits_reg_ff <= w_data_ff[7:0]; // [R6]
      if (wr_hit_ctrl)
        capture_compare_control_ff <= w_data_ff[5:0]; // [R6] [R11]
      if (wr_hit_tctrl)
        timer_ctrl_ff <= w_data_ff[6:0];
      if (wr_hit_dir)
        port_c_direction_ff <= w_data_ff[7:0];
      if (wr_hit_data)
        port_c_data_ff <= w_data_ff[7:0];
    end
  end

  // Postscale event flag: a new event wins over a write-one-to-clear in the same cycle.
  always @(posedge aclk)
  begin
    if (!aresetn)
      post_flag_ff <= 1'b0;
    else if (post_tick)
      post_flag_ff <= 1'b1; // [R13]
    else if (wr_hit_status && w_data_ff[`TBP_ST_POST_FLAG])
      post_flag_ff <= 1'b0;
  end

  // Read data selection.
  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `TBP_RESP_OKAY;
    case (araddr)
      `TBP_OFS_PERIOD:     nxt_rdata[7:0] = period_match_reg_ff;
      `TBP_OFS_TIMER:      nxt_rdata[7:0] = base_timer_count;
      `TBP_OFS_DUTY_HI:    nxt_rdata[7:0] = duty_high_bits_reg_ff;
      `TBP_OFS_SHADOW:     nxt_rdata[7:0] = duty_shadow_reg;
      `TBP_OFS_CTRL:       nxt_rdata[5:0] = capture_compare_control_ff;
      `TBP_OFS_TMR_CTRL:   nxt_rdata[6:0] = timer_ctrl_ff;
      `TBP_OFS_STATUS:
      begin
        nxt_rdata[`TBP_ST_POST_FLAG]  = post_flag_ff;
        nxt_rdata[`TBP_ST_OUT_LEVEL]  = pwm_out;
        nxt_rdata[`TBP_ST_PWM_ACTIVE] = pwm_en;
      end
      `TBP_OFS_PORTC_DIR:  nxt_rdata[7:0] = port_c_direction_ff;
      `TBP_OFS_PORTC_DATA: nxt_rdata[7:0] = port_c_data_ff;
      default:             nxt_rresp = `TBP_RESP_SLVERR;
    endcase
  end

  // Read response, registered one cycle after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `TBP_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rdata  <= nxt_rdata;
      rresp  <= nxt_rresp;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // Pin: the modulation latch replaces the port data only in modulation mode.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      modulated_output_pin    <= 1'b0; // [R16]
      modulated_output_pin_oe <= 1'b0;
    end
    else
    begin
      modulated_output_pin    <= pwm_en ? pwm_out : port_c_data_ff[`TBP_PORTC_PWM_BIT]; // [R11]
      modulated_output_pin_oe <= !port_c_direction_ff[`TBP_PORTC_PWM_BIT]; // [R12]
    end
  end

endmodule // tbp_top

`default_nettype wire

// file: tb/tbp_assertions.sv
// Checker for the bus handshakes and the output pin of the modulation unit.
`timescale 1ns/1ps
`default_nettype none
module tbp_assertions (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Output pin.
  input wire logic        modulated_output_pin,
  input wire logic        modulated_output_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |->
    !modulated_output_pin && !modulated_output_pin_oe)
    else $error("pin or driver active after reset");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered in one cycle");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid)
    else $error("write not answered");
  a_arready_rule: assert property (arready != rvalid)
    else $error("read address ready wrong");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_read_unmapped: assert property (arvalid && arready &&
    (araddr > 8'h20 || araddr[1:0] != 2'h0) |=> rresp == 2'h2 && rdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule // tbp_assertions
bind tbp_top tbp_assertions u_chk (.*);
`default_nettype wire

// file: tb/tbp_load_model.sv
// Load on the modulated pin that measures each period and its high time.
`timescale 1ns/1ps
`default_nettype none
module tbp_load_model (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Pin as seen by the load.
  input  wire logic        pin,
  input  wire logic        oe,
  // Last full period, reported at each rising edge of the pin.
  output logic      [15:0] high_len,
  output logic      [15:0] period_len,
  output logic             done
);
  logic [15:0] cnt_ff;
  logic [15:0] hi_ff;
  logic        prev_ff;
  logic        lvl;
  // The load pulls the line down, so an undriven pin reads low.
  assign lvl = oe & pin;
  always @(posedge aclk)
  begin
    done <= 1'b0;
    prev_ff <= lvl;
    if (!aresetn)
    begin
      cnt_ff <= 16'h0000;
      hi_ff <= 16'h0000;
    end
    else if (lvl && !prev_ff)
    begin
      high_len <= hi_ff;
      period_len <= cnt_ff;
      done <= 1'b1;
      cnt_ff <= 16'h0001;
      hi_ff <= 16'h0001;
    end
    else
    begin
      cnt_ff <= cnt_ff + 16'h0001;
      hi_ff <= hi_ff + {15'h0000, lvl};
    end
  end
endmodule // tbp_load_model
`default_nettype wire

// file: tb/ten_bit_pwm_output_unit_bench.sv
// Self-checking bench for the ten-bit pulse width modulation output unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module ten_bit_pwm_output_unit_bench;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] high_len, period_len;
  wire logic        awready, wready, bvalid, arready, rvalid, pin, oe, done;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          fac;
  logic [31:0] seed = 32'h00002427;
  logic [31:0] r, ep;
  logic [33:0] er;
  logic [1:0]  eb;
  logic [9:0]  d1, d2;
  logic [1:0]  bq [$];
  logic [33:0] rq [$];
  logic [31:0] pq [$];
  logic [7:0]  ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  logic [33:0] rv [10] = '{34'hff, 34'h0, 34'h0, 34'h0, 34'h0, 34'h0, 34'h0, 34'hff, 34'h0,
                           34'h200000000};

  always #20 aclk = ~aclk;

  tbp_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .modulated_output_pin(pin), .modulated_output_pin_oe(oe));
  tbp_load_model u_load (.aclk(aclk), .aresetn(aresetn), .pin(pin), .oe(oe),
    .high_len(high_len), .period_len(period_len), .done(done));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic set_duty(input logic [9:0] d);
    wr(8'h08, {24'h0, d[9:2]}, 2'h0);
    wr(8'h10, {26'h0, d[1:0], 4'hc}, 2'h0);
  endtask

  task automatic wait_done();
    do @(posedge aclk); while (done !== 1'b1);
  endtask

  task automatic hold_lvl(input logic v, input string nm);
    logic ok;
    ok = 1'b1;
    repeat (3) @(posedge aclk);
    repeat (40)
    begin
      @(posedge aclk);
      if (pin !== v) ok = 1'b0;
    end
    `CHK(nm, 1'b1, ok)
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    if (bvalid && bready && bq.size() > 0)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready && rq.size() > 0)
    begin
      er = rq.pop_front();
      `CHK("rdata", er, {rresp, rdata})
    end
  end

  // Measurements are taken half a cycle after the load reports them.
  always @(negedge aclk)
    if (done && pq.size() > 0)
    begin
      ep = pq.pop_front();
      `CHK("period and high time", ep, {period_len, high_len})
    end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(ofs[i], rv[i]);
    wr(8'h28, 32'h1, 2'h2);
    wr(8'h04, 32'h55, 2'h0);
    rd(8'h04, 34'h0);
    wr(8'h0c, 32'h5a, 2'h0);
    rd(8'h0c, 34'h5a);
    wr(8'h20, 32'h4, 2'h0);
    wr(8'h1c, 32'hfb, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK("pin driver", 2'h3, {oe, pin})
    wr(8'h00, 32'h9, 2'h0);
    for (int p = 0; p < 3; p++)
    begin
      fac = 1 << (2 * p);
      r = rnd();
      d1 = 10'(12 + r % 27);
      r = rnd();
      d2 = 10'(12 + r % 27);
      set_duty(d1);
      wr(8'h14, {25'h0, r[3:0], 1'b1, 2'(p)}, 2'h0);
      wait_done();
      wait_done();
      pq.push_back({16'(40 * fac), 16'(d1 * fac)});
      set_duty(d2);
      wait_done();
      pq.push_back({16'(40 * fac), 16'(d2 * fac)});
      wait_done();
    end
    wr(8'h0c, 32'ha5, 2'h0);
    rd(8'h0c, {26'h0, d2[9:2]});
    wr(8'h14, 32'h4, 2'h0);
    set_duty(10'h000);
    repeat (100) @(posedge aclk);
    hold_lvl(1'b0, "zero duty");
    set_duty(10'h3ff);
    repeat (100) @(posedge aclk);
    hold_lvl(1'b1, "long duty");
    rd(8'h18, 34'h7);
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h18, 32'h1, 2'h0);
    rd(8'h18, 34'h0);
    hold_lvl(1'b1, "port latch kept");
    wr(8'h20, 32'h0, 2'h0);
    hold_lvl(1'b0, "port latch low");
    report_and_stop();
  end
endmodule // ten_bit_pwm_output_unit_bench
`default_nettype wire
